/* logic/irqep_pkg.sv */
// Purpose: Shared constants and carrier types for the interrupt enable and pending block.
// Assumes: One 32-bit word per register on the private peripheral bus.
// Notes: Addresses are the full byte addresses seen by the processor.
package irqep_pkg;

	localparam int MAX_IRQ = 32;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 32;

	////////////////////////////////////////////////////////////////////////////////
	// Register map.
	localparam logic [ADDR_W-1:0] ADDR_ENABLE_SET = 32'he000_e100;
	localparam logic [ADDR_W-1:0] ADDR_ENABLE_CLEAR = 32'he000_e180;
	localparam logic [ADDR_W-1:0] ADDR_PENDING_SET = 32'he000_e200;

	localparam logic [DATA_W-1:0] RESET_ENABLE = 32'h0000_0000;
	localparam logic [DATA_W-1:0] RESET_PENDING = 32'h0000_0000;
	localparam logic [DATA_W-1:0] RESET_ACTIVE = 32'h0000_0000;
	localparam logic [DATA_W-1:0] READ_UNMAPPED = 32'h0000_0000;

	////////////////////////////////////////////////////////////////////////////////
	// Carriers.
	typedef enum logic [1:0] {
		SEL_NONE,
		SEL_ENABLE_SET,
		SEL_ENABLE_CLEAR,
		SEL_PENDING_SET
	} irqep_sel_type;

	typedef struct packed {
		logic valid;
		logic write;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} irqep_req_type;

	typedef struct packed {
		logic valid;
		logic [DATA_W-1:0] rdata;
	} irqep_rsp_type;

	function automatic irqep_sel_type irqep_decode(input logic [ADDR_W-1:0] addr);
		if (addr == ADDR_ENABLE_SET) begin
			return SEL_ENABLE_SET;
		end else if (addr == ADDR_ENABLE_CLEAR) begin
			return SEL_ENABLE_CLEAR;
		end else if (addr == ADDR_PENDING_SET) begin
			return SEL_PENDING_SET;
		end else begin
			return SEL_NONE;
		end
	endfunction : irqep_decode

endpackage : irqep_pkg

/* logic/irqep_line_sync.sv */
// Purpose: Brings interrupt lines into the processor clock and finds rising edges.
// Assumes: Lines are active high and may change at any time.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ps
module irqep_line_sync #(
	parameter int WIDTH = 32
) (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic [WIDTH-1:0] lineIn,
	output logic [WIDTH-1:0] lineLevel,
	output logic [WIDTH-1:0] lineRise
);

	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] sync;
		logic [WIDTH-1:0] prev;
	} irqep_sync_state_type;

	irqep_sync_state_type state;
	irqep_sync_state_type next_state;

	always_comb begin
		next_state = state;
		next_state.meta = lineIn;
		next_state.sync = state.meta;
		next_state.prev = state.sync;
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign lineLevel = state.sync;
	// A line held high across reset release shows as an edge once, which is harmless.
	assign lineRise = state.sync & ~state.prev;

endmodule : irqep_line_sync

/* logic/irqep_regs.sv */
// Purpose: Enable, pending and active state for up to 32 external interrupts.
// Assumes: Core entry and return strobes are one-hot pulses on clk_sys.
// Notes: Register reads answer one cycle after the request.
`timescale 1ns/1ps

// Notes on behaviour
// [RULE1] The enable-set register is 32 bits with bit n serving interrupt n.
// [RULE2] Reading the enable-set register returns 1 for enabled and 0 for disabled interrupts.
// [RULE3] Writing 1 to an enable-set bit enables that interrupt and leaves the others alone.
// [RULE4] Writing 0 to any bit of the three registers changes nothing.
// [RULE5] The enable-clear register is 32 bits and reads back the same enable state.
// [RULE6] Writing 1 to an enable-clear bit disables that interrupt against new activation.
// [RULE7] The pending-set register is 32 bits with bit n serving interrupt n.
// [RULE8] Reading the pending-set register returns 1 for pending and 0 for idle interrupts.
// [RULE9] Writing 1 to a pending-set bit makes that interrupt pending like its line would.
// [RULE10] A disabled interrupt still becomes pending but is not activated until enabled.
// [RULE11] Disabling an active interrupt keeps it active until reset or exception return.
// [RULE12] Enable and pending state of all interrupts reset to zero.
// [RULE13] Both enable registers act on one shared enable vector.
module irqep_regs #(
	parameter int NUM_IRQ = 32
) (
	input wire logic clk_sys,
	input wire logic srst,
	input wire irqep_pkg::irqep_req_type busReq,
	output irqep_pkg::irqep_rsp_type busRsp,
	input wire logic [NUM_IRQ-1:0] irqLine,
	input wire logic [NUM_IRQ-1:0] entryGrant,
	input wire logic [NUM_IRQ-1:0] excReturn,
	output logic [NUM_IRQ-1:0] enableOut,
	output logic [NUM_IRQ-1:0] pendingOut,
	output logic [NUM_IRQ-1:0] activeOut,
	output logic [NUM_IRQ-1:0] requestOut
);

	////////////////////////////////////////////////////////////////////////////////
	// Elaboration checks.
	if (NUM_IRQ < 1 || NUM_IRQ > irqep_pkg::MAX_IRQ) begin : g_bad_num
		$error("NUM_IRQ must be between 1 and 32.");
	end

	typedef struct packed {
		logic [NUM_IRQ-1:0] enable;
		logic [NUM_IRQ-1:0] pending;
		logic [NUM_IRQ-1:0] active;
		logic [NUM_IRQ-1:0] request;
		irqep_pkg::irqep_rsp_type rsp;
	} irqep_state_type;

	irqep_state_type state;
	irqep_state_type next_state;

	logic [NUM_IRQ-1:0] lineLevel;
	logic [NUM_IRQ-1:0] lineRise;
	irqep_pkg::irqep_sel_type sel;
	logic [NUM_IRQ-1:0] wbits;
	logic [NUM_IRQ-1:0] pend_assert_bits;
	logic [NUM_IRQ-1:0] activate;
	logic [irqep_pkg::DATA_W-1:0] rdWord;

	irqep_line_sync #(
		.WIDTH(NUM_IRQ)
	) u_sync (
		.clk_sys(clk_sys),
		.srst(srst),
		.lineIn(irqLine),
		.lineLevel(lineLevel),
		.lineRise(lineRise)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Next state.
	always_comb begin
		next_state = state;
		sel = irqep_pkg::irqep_decode(busReq.addr);
		// Bits above NUM_IRQ have no interrupt behind them and are dropped here.
		wbits = busReq.wdata[NUM_IRQ-1:0]; // [RULE1] [RULE7]
		rdWord = irqep_pkg::READ_UNMAPPED;
		// Only entry to an enabled, pending interrupt activates it.
		activate = entryGrant & state.enable & state.pending; // [RULE10]
		// A level still high at exception return re-pends, as an edge would.
		pend_assert_bits = lineRise | (lineLevel & excReturn); // [RULE10]
		if (busReq.valid && busReq.write && sel == irqep_pkg::SEL_ENABLE_SET) begin
			next_state.enable = state.enable | wbits; // [RULE3] [RULE4] [RULE13]
		end else if (busReq.valid && busReq.write && sel == irqep_pkg::SEL_ENABLE_CLEAR) begin
			next_state.enable = state.enable & ~wbits; // [RULE6] [RULE4] [RULE13]
		end else if (busReq.valid && busReq.write && sel == irqep_pkg::SEL_PENDING_SET) begin
			pend_assert_bits = pend_assert_bits | wbits; // [RULE9] [RULE4]
		end
		// A new assertion wins over the clear made by exception entry.
		next_state.pending = pend_assert_bits | (state.pending & ~activate); // [RULE10]
		// Disabling does not touch active bits; only return or reset clears them.
		next_state.active = activate | (state.active & ~excReturn); // [RULE11]
		next_state.request = next_state.enable & next_state.pending & ~next_state.active;
		if (sel == irqep_pkg::SEL_ENABLE_SET || sel == irqep_pkg::SEL_ENABLE_CLEAR) begin
			rdWord[NUM_IRQ-1:0] = state.enable; // [RULE2] [RULE5] [RULE13]
		end else if (sel == irqep_pkg::SEL_PENDING_SET) begin
			rdWord[NUM_IRQ-1:0] = state.pending; // [RULE8]
		end
		next_state.rsp.valid = busReq.valid;
		next_state.rsp.rdata = (busReq.valid && !busReq.write) ? rdWord : irqep_pkg::READ_UNMAPPED;
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			state.enable <= irqep_pkg::RESET_ENABLE[NUM_IRQ-1:0]; // [RULE12]
			state.pending <= irqep_pkg::RESET_PENDING[NUM_IRQ-1:0]; // [RULE12]
			state.active <= irqep_pkg::RESET_ACTIVE[NUM_IRQ-1:0];
			state.request <= '0;
			state.rsp <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign busRsp = state.rsp;
	assign enableOut = state.enable;
	assign pendingOut = state.pending;
	assign activeOut = state.active;
	assign requestOut = state.request;

	////////////////////////////////////////////////////////////////////////////////
	// Checks.
	logic [NUM_IRQ-1:0] reqWbits;
	irqep_pkg::irqep_sel_type reqSel;
	logic reqWr;
	logic reqRd;
	assign reqWbits = busReq.wdata[NUM_IRQ-1:0];
	assign reqSel = irqep_pkg::irqep_decode(busReq.addr);
	assign reqWr = busReq.valid && busReq.write;
	assign reqRd = busReq.valid && !busReq.write;
	logic [NUM_IRQ-1:0] pendWrBits;
	logic [NUM_IRQ-1:0] grantHit;
	logic [NUM_IRQ-1:0] levelReturn;
	assign pendWrBits = (reqWr && reqSel == irqep_pkg::SEL_PENDING_SET) ? reqWbits : '0;
	assign grantHit = entryGrant & enableOut & pendingOut;
	assign levelReturn = lineLevel & excReturn;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);

	// Reset is checked with its own disable, since the default one would hide it.
	chk_reset_zero: assert property ( // [RULE12]
		disable iff (1'h0)
		srst |=> enableOut == '0 && pendingOut == '0)
		else $error("Enable or pending not zero after reset.");

	chk_set_enable: assert property ( // [RULE3]
		reqWr && reqSel == irqep_pkg::SEL_ENABLE_SET
		|=> enableOut == ($past(enableOut) | $past(reqWbits)))
		else $error("Enable-set write gave the wrong enable vector.");

	chk_clear_enable: assert property ( // [RULE6]
		reqWr && reqSel == irqep_pkg::SEL_ENABLE_CLEAR
		|=> enableOut == ($past(enableOut) & ~$past(reqWbits)))
		else $error("Enable-clear write gave the wrong enable vector.");

	chk_enable_hold: assert property ( // [RULE4]
		!(reqWr && (reqSel == irqep_pkg::SEL_ENABLE_SET || reqSel == irqep_pkg::SEL_ENABLE_CLEAR))
		|=> $stable(enableOut))
		else $error("Enable changed without a write.");

	chk_pend_write: assert property ( // [RULE9]
		reqWr && reqSel == irqep_pkg::SEL_PENDING_SET
		|=> (pendingOut & $past(reqWbits)) == $past(reqWbits))
		else $error("Pending-set write did not pend.");

	chk_read_enable: assert property ( // [RULE2] [RULE5] [RULE13]
		reqRd && (reqSel == irqep_pkg::SEL_ENABLE_SET || reqSel == irqep_pkg::SEL_ENABLE_CLEAR)
		|=> busRsp.valid && busRsp.rdata[NUM_IRQ-1:0] == $past(enableOut))
		else $error("Enable readback wrong.");

	chk_read_pend: assert property ( // [RULE8]
		reqRd && reqSel == irqep_pkg::SEL_PENDING_SET
		|=> busRsp.valid && busRsp.rdata[NUM_IRQ-1:0] == $past(pendingOut))
		else $error("Pending readback wrong.");

	chk_edge_pends: assert property ( // [RULE10]
		1'h1
		|=> (pendingOut & $past(lineRise)) == $past(lineRise))
		else $error("Line edge did not pend.");

	chk_no_dis_activate: assert property ( // [RULE10]
		(activeOut & ~$past(activeOut) & ~$past(enableOut)) == '0)
		else $error("Disabled interrupt became active.");

	chk_active_kept: assert property ( // [RULE11]
		(($past(activeOut) & ~$past(excReturn)) & ~activeOut) == '0)
		else $error("Active cleared without return.");

	chk_upper_zero: assert property ( // [RULE1] [RULE7]
		reqRd |=> busRsp.rdata >> NUM_IRQ == '0)
		else $error("Unimplemented bits read nonzero.");

	////////////////////////////////////////////////////////////////////////////////
	// Answers and causes of state changes.
	chk_rsp_once: assert property ( // [RULE2] [RULE8]
		1'h1
		|=> busRsp.valid == $past(busReq.valid))
		else $error("Bus answer missing or extra.");

	chk_pend_hold: assert property ( // [RULE4]
		(($past(pendingOut) & ~pendingOut) & ~$past(entryGrant)) == '0)
		else $error("Pending cleared without exception entry.");

	chk_pend_cause: assert property ( // [RULE4] [RULE9]
		(pendingOut & ~$past(pendingOut) & ~$past(lineRise) & ~$past(levelReturn)
			& ~$past(pendWrBits)) == '0)
		else $error("Pending set without a cause.");

	chk_activate_grant: assert property ( // [RULE10]
		1'h1
		|=> (activeOut & $past(grantHit)) == $past(grantHit))
		else $error("Entry to an enabled pending interrupt did not activate it.");

	chk_active_cause: assert property ( // [RULE10]
		(activeOut & ~$past(activeOut) & ~$past(grantHit)) == '0)
		else $error("Interrupt became active without entry.");

	chk_return_clears: assert property ( // [RULE11]
		1'h1
		|=> (activeOut & $past(excReturn) & ~$past(grantHit)) == '0)
		else $error("Exception return left the interrupt active.");

	chk_level_repend: assert property ( // [RULE10]
		1'h1
		|=> (pendingOut & $past(levelReturn)) == $past(levelReturn))
		else $error("Level still high at return did not pend again.");

	////////////////////////////////////////////////////////////////////////////////
	// Main scenarios.
	cov_enable_write: cover property (reqWr && reqSel == irqep_pkg::SEL_ENABLE_SET && reqWbits != '0);
	cov_pend_disabled: cover property ((lineRise & ~enableOut) != '0
		##1 (pendingOut & ~enableOut) != '0);
	cov_activate: cover property ((activeOut & ~$past(activeOut)) != '0);
	cov_disable_active: cover property (reqWr && reqSel == irqep_pkg::SEL_ENABLE_CLEAR
		&& (reqWbits & activeOut) != '0);
	cov_level_repend: cover property (levelReturn != '0);

endmodule : irqep_regs

/* verification/irqep_core_model.sv */
// Purpose: Behavioural processor core that drives the register bus and the core strobes.
// Assumes: The block answers every request exactly one cycle after taking it.
// Notes: Idle bus fields carry the inverse of the last request, so stale values are never trusted.
`timescale 1ns/1ps
module irqep_core_model (
	input wire logic clk_sys,
	input wire irqep_pkg::irqep_rsp_type busRsp,
	output irqep_pkg::irqep_req_type busReq,
	output logic [31:0] entryGrant,
	output logic [31:0] excReturn
);
	initial begin
		busReq = '0;
		entryGrant = '0;
		excReturn = '0;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic access(input logic wr, input logic [31:0] addr, input logic [31:0] wdata,
			output logic [31:0] rdata, output logic ok);
		@(posedge clk_sys);
		busReq <= '{valid: 1'b1, write: wr, addr: addr, wdata: wdata};
		@(posedge clk_sys);
		busReq <= '{valid: 1'b0, write: ~wr, addr: ~addr, wdata: ~wdata};
		#1;
		ok = busRsp.valid;
		rdata = busRsp.rdata;
	endtask : access

	task automatic pulse(input logic ret, input int n);
		@(posedge clk_sys);
		if (ret) begin
			excReturn <= 32'h1 << n;
		end else begin
			entryGrant <= 32'h1 << n;
		end
		@(posedge clk_sys);
		entryGrant <= '0;
		excReturn <= '0;
		#1;
	endtask : pulse
endmodule : irqep_core_model

/* verification/irq_enable_pending_regs_tb_top.sv */
// Purpose: Self-checking bench for the interrupt enable and pending registers.
// Assumes: Inputs change on the rising edge by non-blocking assignment.
// Notes: Expected state lives in the bench and is never read back from the design.
`timescale 1ns/1ps
module irq_enable_pending_regs_tb_top;
	logic clk_sys = 1'b0;
	logic srst = 1'b1;
	logic [31:0] irqLine = '0;
	logic [31:0] lfsr = 32'h6df5dd14;
	logic [31:0] expEn, expPd, rd, data, entryGrant, excReturn;
	logic [31:0] enableOut, pendingOut, activeOut, requestOut;
	logic [1:0] sel;
	logic ok;
	int n;
	int bad_count = 0;
	int check_count = 0;
	irqep_pkg::irqep_req_type busReq;
	irqep_pkg::irqep_rsp_type busRsp;
	// Entry 0 is a reserved address that must be answered but ignored.
	logic [31:0] addrTab [4] = '{32'he000_e104, irqep_pkg::ADDR_ENABLE_SET,
		irqep_pkg::ADDR_ENABLE_CLEAR, irqep_pkg::ADDR_PENDING_SET};

	always #4 clk_sys = ~clk_sys;

	irqep_regs #(.NUM_IRQ(32)) dut_u (.clk_sys(clk_sys), .srst(srst), .busReq(busReq),
		.busRsp(busRsp), .irqLine(irqLine), .entryGrant(entryGrant), .excReturn(excReturn),
		.enableOut(enableOut), .pendingOut(pendingOut), .activeOut(activeOut),
		.requestOut(requestOut));
	irqep_core_model core_u (.clk_sys(clk_sys), .busRsp(busRsp), .busReq(busReq),
		.entryGrant(entryGrant), .excReturn(excReturn));

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] nextLfsr(input logic [31:0] x);
		return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c1_1db7 : 32'h0);
	endfunction : nextLfsr

	function automatic logic [63:0] expWrite(input logic [1:0] s, input logic [31:0] d,
			input logic [31:0] en, input logic [31:0] pd);
		case (s)
			2'h1: return {en | d, pd};
			2'h2: return {en & ~d, pd};
			2'h3: return {en, pd | d};
			default: return {en, pd};
		endcase
	endfunction : expWrite

	function automatic logic [31:0] expRead(input int i, input logic [31:0] en,
			input logic [31:0] pd);
		return (i == 0) ? 32'h0 : (i == 3) ? pd : en;
	endfunction : expRead

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : test_done

	task automatic doReset();
		@(posedge clk_sys);
		srst <= 1'b1;
		repeat (4) @(posedge clk_sys);
		srst <= 1'b0;
		expEn = '0;
		expPd = '0;
	endtask : doReset

	// Reads the reserved word and all three registers; both enable views must agree.
	task automatic readAll();
		for (int i = 0; i < 4; i++) begin
			core_u.access(1'b0, addrTab[i], 32'h0, rd, ok);
			check({31'h0, ok}, 32'h1);
			check(rd, expRead(i, expEn, expPd));
		end
	endtask : readAll

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (4) @(posedge clk_sys);
		srst <= 1'b0;
		expEn = '0;
		expPd = '0;
		readAll();
		// Sparse data keeps pending from saturating; the mid-run reset restarts from zero.
		for (int k = 0; k < 40; k++) begin
			if (k == 20) doReset();
			lfsr = nextLfsr(lfsr);
			sel = lfsr[1:0];
			lfsr = nextLfsr(lfsr);
			data = lfsr & nextLfsr(lfsr);
			core_u.access(1'b1, addrTab[sel], data, rd, ok);
			{expEn, expPd} = expWrite(sel, data, expEn, expPd);
			check(enableOut, expEn);
			check(pendingOut, expPd);
			readAll();
		end
		doReset();
		@(posedge clk_sys);
		irqLine <= 32'h20;
		expPd = 32'h20;
		for (n = 0; n < 8 && pendingOut[5] !== 1'b1; n++) @(posedge clk_sys);
		check(pendingOut, expPd);
		core_u.pulse(1'b0, 5);
		check(activeOut, 32'h0);
		@(posedge clk_sys);
		irqLine <= '0;
		core_u.access(1'b1, irqep_pkg::ADDR_ENABLE_SET, 32'h20, rd, ok);
		expEn = 32'h20;
		check(requestOut, 32'h20);
		core_u.pulse(1'b0, 5);
		expPd = '0;
		check(activeOut, 32'h20);
		check(pendingOut, expPd);
		core_u.access(1'b1, irqep_pkg::ADDR_ENABLE_CLEAR, 32'h20, rd, ok);
		expEn = '0;
		check(activeOut, 32'h20);
		check(requestOut, 32'h0);
		core_u.pulse(1'b1, 5);
		check(activeOut, 32'h0);
		// A level still high at exception return must pend again.
		@(posedge clk_sys);
		irqLine <= 32'h80;
		core_u.access(1'b1, irqep_pkg::ADDR_ENABLE_SET, 32'h80, rd, ok);
		expEn = 32'h80;
		repeat (2) @(posedge clk_sys);
		check(requestOut, 32'h80);
		core_u.pulse(1'b0, 7);
		check(activeOut, 32'h80);
		check(pendingOut, 32'h0);
		core_u.pulse(1'b1, 7);
		expPd = 32'h80;
		check(pendingOut, expPd);
		check(activeOut, 32'h0);
		@(posedge clk_sys);
		irqLine <= '0;
		readAll();
		test_done();
	end
endmodule : irq_enable_pending_regs_tb_top
